// [freq_jitter.sv]
// hardware frequency jitter sequencer with section timer and register port
//
// Functional notes
// - section timer steps four intervals, each length from its own register
// - timer starts on external rising edge or run bit, chosen by source select
// - external select picks overvoltage comparator or trigger pin
// - first and fourth intervals use count, approach or unchanged behaviour
// - approach in first and fourth intervals keeps counts and steps fixed
// - first interval aims at set B, fourth interval at set A
// - unchanged mode leaves period and duty to software writes
// - second and third intervals approach and update counts and steps
// - second interval aims at set A, third at set B
// - untimed rest after fourth interval, no automatic adjustment
// - hardware mode bit plus approach and partial selects pick the mode
// - within one step, load target into period and set reached flag
// - limit enabled, rising outside the step, and period plus step above maximum sets limit flag
// - three-bit read-only section indicator shows the current interval
// - outside the step, period moves by step, duty too if positive
// - within the step, duty moves by half the difference if positive
// - software mode starts on enable bit, hardware on run bit or edge
// - modulator stopped freezes period and clears counter to zero; trigger counter steps on overflow
// - resonance guard clears software enable and hands output to protection
// - auto-adjust flag ignores all three starts and clears their set request
// - trigger select encoding: source 1 run bit, else comparator or pin
// - resonance guard stops jittering and clears run and enable bits
`timescale 1ns/1ps
`default_nettype none
module freq_jitter (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic overvoltage_cmp_out,
  input wire logic external_trigger_pin,
  input wire logic resonance_guard,
  input wire logic auto_adjust_flag,
  output logic [11:0] period_value,
  output logic [11:0] duty_value,
  output logic [11:0] deadtime_first,
  output logic [11:0] deadtime_second,
  output logic period_tick,
  output logic guard_owns_output
);
  typedef struct packed {
    logic hw_run;
    logic sw_en;
    logic hw_mode;
    logic appr_sel;
    logic part_sel;
    logic src_sel;
    logic ext_sel;
    logic mod_run;
    logic lim_en;
    logic guard;
    logic rch_a;
    logic rch_b;
    logic lim_a;
    logic lim_b;
    logic [11:0] period;
    logic [11:0] duty;
    logic [11:0] dt0;
    logic [11:0] dt1;
    logic [11:0] pmax;
    logic [11:0] tpa;
    logic [11:0] tpb;
    logic [11:0] td0a;
    logic [11:0] td0b;
    logic [11:0] td1a;
    logic [11:0] td1b;
    logic [3:0][15:0] dur;
    logic [2:0] trig_cnt;
    logic [2:0] pstep;
    logic [1:0] pupd;
    logic [2:0] dstep;
    logic [1:0] dupd;
    logic dt_en;
    logic [2:0] ctrig;
    logic [2:0] cstep;
    logic cdown;
    jitter_pkg::section_t sect;
    logic [15:0] stimer;
    logic [11:0] pcnt;
    logic [2:0] trig;
    logic tick;
    logic [15:0] rdata;
  } state_t;
  state_t q;
  state_t n;

  logic ovp_rise;
  logic pin_rise;

  // comparator and pin each pass their own synchroniser
  edge_sync ovp_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .din(overvoltage_cmp_out),
    .rise(ovp_rise)
  );
  edge_sync pin_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .din(external_trigger_pin),
    .rise(pin_rise)
  );

  // one step of a value toward its target
  function automatic logic [11:0] toward(input logic [11:0] c, input logic [11:0] t,
                                         input logic [11:0] s);
    if (c < t) begin
      toward = (t - c <= s) ? t : c + s;
    end else begin
      toward = (c - t <= s) ? t : c - s;
    end
  endfunction

  // step value nudged up or down, held inside 0..7
  function automatic logic [2:0] nudge(input logic [2:0] v, input logic [1:0] u);
    nudge = v;
    if (u == jitter_pkg::UPD_INC && v != 3'h7) begin
      nudge = v + 3'h1;
    end else if (u == jitter_pkg::UPD_DEC && v != 3'h0) begin
      nudge = v - 3'h1;
    end
  endfunction

  logic ctrl_wr;
  logic run_rise;
  logic ovf;
  logic fire;
  logic in_t;
  logic edge_t;
  logic aim_b;
  logic do_appr;
  logic do_cnt;
  logic up;
  logic start;
  logic [2:0] trig_lim;
  logic [11:0] tp;
  logic [11:0] diff;
  logic [11:0] step;
  logic [11:0] half;

  always_comb begin
    n = q;
    n.tick = 1'b0;
    ctrl_wr = wr && addr == jitter_pkg::A_CTRL;
    run_rise = 1'b0;
    ovf = 1'b0;
    fire = 1'b0;
    start = 1'b0;
    up = 1'b0;
    tp = 12'h000;
    diff = 12'h000;
    half = 12'h000;
    step = {9'h000, q.pstep};

    // software writes land first, hardware updates below may follow
    if (ctrl_wr) begin
      n.hw_run = wdata[jitter_pkg::C_HW_RUN];
      n.sw_en = wdata[jitter_pkg::C_SW_EN];
      n.hw_mode = wdata[jitter_pkg::C_HW_MODE];
      n.appr_sel = wdata[jitter_pkg::C_APPR_SEL];
      n.part_sel = wdata[jitter_pkg::C_PART_SEL];
      n.src_sel = wdata[jitter_pkg::C_SRC_SEL];
      n.ext_sel = wdata[jitter_pkg::C_EXT_SEL];
      n.mod_run = wdata[jitter_pkg::C_MOD_RUN];
      n.lim_en = wdata[jitter_pkg::C_LIM_EN];
      run_rise = wdata[jitter_pkg::C_MOD_RUN] & ~q.mod_run;
    end
    // status flags clear by writing one
    if (wr && addr == jitter_pkg::A_STAT) begin
      n.rch_a = q.rch_a & ~wdata[0];
      n.rch_b = q.rch_b & ~wdata[1];
      n.lim_a = q.lim_a & ~wdata[2];
      n.lim_b = q.lim_b & ~wdata[3];
    end
    // value registers, period and duty stay writable in every section
    if (wr) begin
      unique case (addr)
        jitter_pkg::A_PER: n.period = wdata[11:0];
        jitter_pkg::A_DUTY: n.duty = wdata[11:0];
        jitter_pkg::A_DT0: n.dt0 = wdata[11:0];
        jitter_pkg::A_DT1: n.dt1 = wdata[11:0];
        jitter_pkg::A_PMAX: n.pmax = wdata[11:0];
        jitter_pkg::A_TPA: n.tpa = wdata[11:0];
        jitter_pkg::A_TPB: n.tpb = wdata[11:0];
        jitter_pkg::A_TD0A: n.td0a = wdata[11:0];
        jitter_pkg::A_TD0B: n.td0b = wdata[11:0];
        jitter_pkg::A_TD1A: n.td1a = wdata[11:0];
        jitter_pkg::A_TD1B: n.td1b = wdata[11:0];
        jitter_pkg::A_APPR: begin
          n.trig_cnt = wdata[jitter_pkg::P_TRIG +: 3];
          n.pstep = wdata[jitter_pkg::P_PSTEP +: 3];
          n.pupd = wdata[jitter_pkg::P_PUPD +: 2];
          n.dstep = wdata[jitter_pkg::P_DSTEP +: 3];
          n.dupd = wdata[jitter_pkg::P_DUPD +: 2];
          n.dt_en = wdata[jitter_pkg::P_DTEN];
        end
        jitter_pkg::A_CNTM: begin
          n.ctrig = wdata[jitter_pkg::K_TRIG +: 3];
          n.cstep = wdata[jitter_pkg::K_STEP +: 3];
          n.cdown = wdata[jitter_pkg::K_DOWN];
        end
        default: ;
      endcase
    end
    for (int i = 0; i < 4; i++) begin
      if (wr && addr == jitter_pkg::A_DUR1 + 5'(i)) begin
        n.dur[i] = wdata;
      end
    end

    // mode decode for the current section
    in_t = q.sect inside {jitter_pkg::S_T1, jitter_pkg::S_T2,
                          jitter_pkg::S_T3, jitter_pkg::S_T4};
    edge_t = q.sect inside {jitter_pkg::S_T1, jitter_pkg::S_T4};
    aim_b = q.sect inside {jitter_pkg::S_T1, jitter_pkg::S_T3};
    do_appr = q.hw_mode && in_t && !(edge_t && q.part_sel)
              && !(edge_t && !q.appr_sel);
    do_cnt = q.hw_mode && edge_t && !q.part_sel && !q.appr_sel;
    trig_lim = do_cnt ? q.ctrig : q.trig_cnt;

    // modulator period counter, cleared to zero while the modulator is stopped
    if (q.mod_run) begin
      if (q.pcnt >= q.period) begin
        n.pcnt = 12'h000;
        ovf = 1'b1;
      end else begin
        n.pcnt = q.pcnt + 12'h001;
      end
    end else begin
      n.pcnt = 12'h000;
    end
    n.tick = ovf;

    // trigger counter steps on overflow or modulator start only
    if (ovf || run_rise) begin
      if (q.trig >= trig_lim) begin
        n.trig = 3'h0;
        fire = do_appr || do_cnt;
      end else begin
        n.trig = q.trig + 3'h1;
      end
    end

    // approach toward the selected target set
    if (fire && do_appr) begin
      tp = aim_b ? q.tpb : q.tpa;
      up = tp > q.period;
      diff = up ? tp - q.period : q.period - tp;
      half = diff >> 1;
      if (diff <= step) begin
        n.period = tp;
        n.rch_a = n.rch_a | ~aim_b;
        n.rch_b = n.rch_b | aim_b;
        if (up) begin
          n.duty = q.duty + half;
        end else if (q.duty > half) begin
          n.duty = q.duty - half;
        end
      end else if (up && q.lim_en && {1'b0, q.period} + {1'b0, step} > {1'b0, q.pmax}) begin
        n.lim_a = n.lim_a | ~aim_b;
        n.lim_b = n.lim_b | aim_b;
      end else if (up) begin
        n.period = q.period + step;
        n.duty = q.duty + step;
      end else begin
        n.period = q.period - step;
        if (q.duty > step) begin
          n.duty = q.duty - step;
        end
      end
      if (q.dt_en) begin
        n.dt0 = toward(q.dt0, aim_b ? q.td0b : q.td0a, {9'h000, q.dstep});
        n.dt1 = toward(q.dt1, aim_b ? q.td1b : q.td1a, {9'h000, q.dstep});
      end
      // counts and steps move only in the middle sections
      if (!edge_t) begin
        n.trig_cnt = nudge(q.trig_cnt, q.pupd);
        n.pstep = nudge(q.pstep, q.pupd);
        n.dstep = nudge(q.dstep, q.dupd);
      end
    end

    // count mode moves period and duty by a fixed step
    if (fire && do_cnt) begin
      if (q.cdown) begin
        n.period = q.period - {9'h000, q.cstep};
        if (q.duty > {9'h000, q.cstep}) begin
          n.duty = q.duty - {9'h000, q.cstep};
        end
      end else begin
        n.period = q.period + {9'h000, q.cstep};
        n.duty = q.duty + {9'h000, q.cstep};
      end
    end

    // start source: run bit rising or selected external edge, new settings count at once
    if (n.src_sel) begin
      start = ctrl_wr && wdata[jitter_pkg::C_HW_RUN] && !q.hw_run;
    end else begin
      start = n.ext_sel ? pin_rise : ovp_rise;
    end

    // section timer
    if (!n.hw_mode) begin
      n.sect = jitter_pkg::S_IDLE;
    end else if ((start || (ctrl_wr && wdata[jitter_pkg::C_HW_RUN] && !q.hw_run))
                 && auto_adjust_flag) begin
      n.hw_run = 1'b0;
    end else if (start && n.mod_run && !in_t) begin
      n.sect = jitter_pkg::S_T1;
      n.stimer = q.dur[0];
      n.hw_run = 1'b1;
    end else if (ctrl_wr && !wdata[jitter_pkg::C_HW_RUN] && in_t) begin
      n.sect = jitter_pkg::S_REST;
    end else if (in_t && q.mod_run) begin
      if (q.stimer == 16'h0000) begin
        unique case (q.sect)
          jitter_pkg::S_T1: begin
            n.sect = jitter_pkg::S_T2;
            n.stimer = q.dur[1];
          end
          jitter_pkg::S_T2: begin
            n.sect = jitter_pkg::S_T3;
            n.stimer = q.dur[2];
          end
          jitter_pkg::S_T3: begin
            n.sect = jitter_pkg::S_T4;
            n.stimer = q.dur[3];
          end
          default: begin
            n.sect = jitter_pkg::S_REST;
            n.hw_run = 1'b0;
          end
        endcase
      end else begin
        n.stimer = q.stimer - 16'h0001;
      end
    end

    // software enable refused or dropped while auto-adjust is active
    if (auto_adjust_flag && n.sw_en) begin
      n.sw_en = 1'b0;
    end else if (n.sw_en && !q.sw_en) begin
      n.guard = 1'b0;
    end

    // resonance guard stops the section timer, clears run and enable, and takes the output
    if (resonance_guard) begin
      n.hw_run = 1'b0;
      n.sw_en = 1'b0;
      n.sect = jitter_pkg::S_IDLE;
      n.guard = 1'b1;
    end

    // read data stand in the cycle after the strobe only
    n.rdata = 16'h0000;
    if (rd) begin
      unique case (addr)
        jitter_pkg::A_CTRL: n.rdata = {6'h00, q.guard, q.lim_en, q.mod_run,
          q.ext_sel, q.src_sel, q.part_sel, q.appr_sel, q.hw_mode, q.sw_en, q.hw_run};
        jitter_pkg::A_STAT: n.rdata = {9'h000, q.sect,
          q.lim_b, q.lim_a, q.rch_b, q.rch_a};
        jitter_pkg::A_PER: n.rdata = {4'h0, q.period};
        jitter_pkg::A_DUTY: n.rdata = {4'h0, q.duty};
        jitter_pkg::A_DT0: n.rdata = {4'h0, q.dt0};
        jitter_pkg::A_DT1: n.rdata = {4'h0, q.dt1};
        jitter_pkg::A_PMAX: n.rdata = {4'h0, q.pmax};
        jitter_pkg::A_TPA: n.rdata = {4'h0, q.tpa};
        jitter_pkg::A_TPB: n.rdata = {4'h0, q.tpb};
        jitter_pkg::A_TD0A: n.rdata = {4'h0, q.td0a};
        jitter_pkg::A_TD0B: n.rdata = {4'h0, q.td0b};
        jitter_pkg::A_TD1A: n.rdata = {4'h0, q.td1a};
        jitter_pkg::A_TD1B: n.rdata = {4'h0, q.td1b};
        jitter_pkg::A_APPR: n.rdata = {2'h0, q.dt_en, q.dupd, q.dstep,
          q.pupd, q.pstep, q.trig_cnt};
        jitter_pkg::A_CNTM: n.rdata = {9'h000, q.cdown, q.cstep, q.ctrig};
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (addr == jitter_pkg::A_DUR1 + 5'(i)) begin
              n.rdata = q.dur[i];
            end
          end
        end
      endcase
    end
  end

  // whole state in one register, frozen while ce is low
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  // outputs come straight from the state register
  assign rdata = q.rdata;
  assign period_value = q.period;
  assign duty_value = q.duty;
  assign deadtime_first = q.dt0;
  assign deadtime_second = q.dt1;
  assign period_tick = q.tick;
  assign guard_owns_output = q.guard;
endmodule
`default_nettype wire

// [jitter_pkg.sv]
// constants and state codes for the frequency jitter sequencer
package jitter_pkg;
  // register word addresses
  localparam logic [4:0] A_CTRL = 5'h00;
  localparam logic [4:0] A_STAT = 5'h01;
  localparam logic [4:0] A_PER = 5'h02;
  localparam logic [4:0] A_DUTY = 5'h03;
  localparam logic [4:0] A_DT0 = 5'h04;
  localparam logic [4:0] A_DT1 = 5'h05;
  localparam logic [4:0] A_PMAX = 5'h06;
  localparam logic [4:0] A_TPA = 5'h07;
  localparam logic [4:0] A_TPB = 5'h08;
  localparam logic [4:0] A_TD0A = 5'h09;
  localparam logic [4:0] A_TD0B = 5'h0A;
  localparam logic [4:0] A_TD1A = 5'h0B;
  localparam logic [4:0] A_TD1B = 5'h0C;
  localparam logic [4:0] A_DUR1 = 5'h0D;
  localparam logic [4:0] A_APPR = 5'h11;
  localparam logic [4:0] A_CNTM = 5'h12;
  // control register bit positions
  localparam int C_HW_RUN = 0;
  localparam int C_SW_EN = 1;
  localparam int C_HW_MODE = 2;
  localparam int C_APPR_SEL = 3;
  localparam int C_PART_SEL = 4;
  localparam int C_SRC_SEL = 5;
  localparam int C_EXT_SEL = 6;
  localparam int C_MOD_RUN = 7;
  localparam int C_LIM_EN = 8;
  localparam int C_GUARD = 9;
  // status register bit positions
  localparam int S_SECT = 4;
  // approach control field positions
  localparam int P_TRIG = 0;
  localparam int P_PSTEP = 3;
  localparam int P_PUPD = 6;
  localparam int P_DSTEP = 8;
  localparam int P_DUPD = 11;
  localparam int P_DTEN = 13;
  // count control field positions
  localparam int K_TRIG = 0;
  localparam int K_STEP = 3;
  localparam int K_DOWN = 6;
  // step update codes
  localparam logic [1:0] UPD_INC = 2'h1;
  localparam logic [1:0] UPD_DEC = 2'h2;
  // reset value of every register
  localparam logic [15:0] REG_RST = 16'h0000;
  // section timer states, code equals the section indicator
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_T1 = 3'h1,
    S_T2 = 3'h2,
    S_T3 = 3'h3,
    S_T4 = 3'h4,
    S_REST = 3'h5
  } section_t;
endpackage

// [edge_sync.sv]
// three-stage synchroniser with agreement filter and rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic din,
  output logic rise
);
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic stable;
    logic rise;
  } sync_t;
  sync_t q;
  sync_t n;

  // stable level moves only when the second and third stages agree
  always_comb begin
    n = q;
    n.ff1 = din;
    n.ff2 = q.ff1;
    n.ff3 = q.ff2;
    n.rise = 1'b0;
    if (q.ff2 == q.ff3) begin
      n.stable = q.ff3;
      n.rise = q.ff3 & ~q.stable;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  assign rise = q.rise;
endmodule
`default_nettype wire

// [freq_jitter_sva.sv]
// port assertions for the frequency jitter sequencer
`timescale 1ns/1ps
`default_nettype none
module freq_jitter_chk (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic overvoltage_cmp_out,
  input wire logic external_trigger_pin,
  input wire logic resonance_guard,
  input wire logic auto_adjust_flag,
  input wire logic [11:0] period_value,
  input wire logic [11:0] duty_value,
  input wire logic [11:0] deadtime_first,
  input wire logic [11:0] deadtime_second,
  input wire logic period_tick,
  input wire logic guard_owns_output
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // register access steps
  sequence s_rd(a);
    rd && ce && addr == a;
  endsequence
  sequence s_wr(a);
    wr && ce && addr == a;
  endsequence
  // targets only change through software writes
  AST_TARGET_HOLD: assert property (
    s_wr(jitter_pkg::A_TPA) ##2 s_rd(jitter_pkg::A_TPA) |=>
    rdata == {4'h0, $past(wdata[11:0], 3)}) else $error("target period not as written");
  AST_START_IGNORED: assert property (
    (wr && addr == jitter_pkg::A_CTRL && wdata[0] && auto_adjust_flag) ##2
    s_rd(jitter_pkg::A_CTRL) |=> !rdata[jitter_pkg::C_HW_RUN]) else $error("start not refused");
  AST_GUARD_CLEARS: assert property (
    resonance_guard ##1 s_rd(jitter_pkg::A_CTRL) |=> rdata[1:0] == 2'h0)
    else $error("guard left run or enable set");
  AST_GUARD_OWNS: assert property (resonance_guard |=> guard_owns_output)
    else $error("guard did not take the output");
  AST_OWN_RELEASE: assert property (
    $fell(guard_owns_output) |-> $past(wr) || $past(wr, 2))
    else $error("output handed back without a write");
  AST_SECT_CODE: assert property (
    s_rd(jitter_pkg::A_STAT) |=> rdata[6:4] <= 3'h5 && rdata[15:7] == 9'h000)
    else $error("section indicator out of range");
  AST_UNMAPPED: assert property (
    rd && addr > jitter_pkg::A_CNTM |=> rdata == 16'h0000) else $error("unmapped read not zero");
  AST_TICK_PULSE: assert property (
    period_tick && ce && period_value != 12'h000 |=> !period_tick)
    else $error("tick longer than a cycle");
  AST_PERIOD_CAUSE: assert property (
    $changed(period_value) |-> $past(wr) || $past(wr, 2) || period_tick ||
    $past(period_tick) || $past(period_tick, 2)) else $error("period moved with no cause");
endmodule
bind freq_jitter freq_jitter_chk chk (
  .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .overvoltage_cmp_out(overvoltage_cmp_out),
  .external_trigger_pin(external_trigger_pin), .resonance_guard(resonance_guard),
  .auto_adjust_flag(auto_adjust_flag), .period_value(period_value), .duty_value(duty_value),
  .deadtime_first(deadtime_first), .deadtime_second(deadtime_second),
  .period_tick(period_tick), .guard_owns_output(guard_owns_output)
);
`default_nettype wire

// [freq_jitter_tb_top.sv]
// self-checking bench for the frequency jitter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module freq_jitter_tb_top;
  localparam logic [15:0] RUN = 16'h0001 << jitter_pkg::C_HW_RUN;
  localparam logic [15:0] SWEN = 16'h0001 << jitter_pkg::C_SW_EN;
  localparam logic [15:0] HWM = 16'h0001 << jitter_pkg::C_HW_MODE;
  localparam logic [15:0] APS = 16'h0001 << jitter_pkg::C_APPR_SEL;
  localparam logic [15:0] SRC = 16'h0001 << jitter_pkg::C_SRC_SEL;
  localparam logic [15:0] EXT = 16'h0001 << jitter_pkg::C_EXT_SEL;
  localparam logic [15:0] MOD = 16'h0001 << jitter_pkg::C_MOD_RUN;
  localparam logic [15:0] LIM = 16'h0001 << jitter_pkg::C_LIM_EN;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ov_cmp = 1'b0;
  logic ext_pin = 1'b0;
  logic guard = 1'b0;
  logic auto_adj = 1'b0;
  logic [15:0] rdata;
  logic [11:0] per, duty, dt0, dt1;
  logic tick, owns;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int cnt [8];
  logic [15:0] r, d;
  logic [15:0] dur [4];
  logic [2:0] s, st;
  logic [11:0] p0, tg, pm, ed;
  logic [12:0] ex;

  freq_jitter uut (
    .mclk(mclk), .sys_rst(sys_rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .overvoltage_cmp_out(ov_cmp), .external_trigger_pin(ext_pin),
    .resonance_guard(guard), .auto_adjust_flag(auto_adj), .period_value(per),
    .duty_value(duty), .deadtime_first(dt0), .deadtime_second(dt1), .period_tick(tick),
    .guard_owns_output(owns)
  );

  always #5 mclk = ~mclk;

  // expected final period and whether the ceiling stopped the climb
  function automatic logic [12:0] exp_final(input logic [11:0] p, input logic [11:0] t,
      input logic [2:0] sp, input logic lim, input logic [11:0] mx, inout logic [11:0] du);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 64 && p != t && !hit; i++) begin
      if (t - p <= 12'(sp)) begin
        du = du + ((t - p) >> 1);
        p = t;
      end else if (lim && 13'(p) + 13'(sp) > 13'(mx)) begin
        hit = 1'b1;
      end else begin
        p = p + 12'(sp);
        du = du + 12'(sp);
      end
    end
    return {hit, p};
  endfunction

  // register bus cycles
  task automatic wreg(input logic [4:0] a, input logic [15:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, output logic [15:0] v);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    v = rdata;
  endtask
  task automatic sect;
    rreg(jitter_pkg::A_STAT, r);
    s = r[6:4];
  endtask
  // control write, then status read every cycle, counting cycles per section
  task automatic stream(input logic [15:0] c, input int n);
    for (int i = 0; i < 8; i++) cnt[i] = 0;
    @(posedge mclk);
    wr <= 1'b1;
    addr <= jitter_pkg::A_CTRL;
    wdata <= c;
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= jitter_pkg::A_STAT;
    repeat (n) begin
      @(negedge mclk);
      cnt[rdata[6:4]] = cnt[rdata[6:4]] + 1;
    end
    @(posedge mclk);
    rd <= 1'b0;
  endtask
  task automatic tally_and_finish;
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard on the cycle count
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      tally_and_finish;
    end
  end

  initial begin
    void'($urandom(32'h0D3F));
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    // reset values, random read back with the modulator stopped, unmapped place
    for (int a = 0; a <= 18; a++) begin
      rreg(5'(a), r);
      `CHK("reset value", jitter_pkg::REG_RST, r)
    end
    for (int a = 2; a <= 16; a++) begin
      d = 16'($urandom);
      wreg(5'(a), d);
      rreg(5'(a), r);
      `CHK("readback", ((a >= 13) ? d : {4'h0, d[11:0]}), r)
      if (a == 2) `CHK("period pin", d[11:0], per)
      if (a == 3) `CHK("duty pin", d[11:0], duty)
      if (a == 4) `CHK("first deadtime pin", d[11:0], dt0)
      if (a == 5) `CHK("second deadtime pin", d[11:0], dt1)
    end
    rreg(5'h1F, r);
    `CHK("unmapped", 16'h0000, r)
    // run bit start, interval lengths with a one-cycle first interval, rest
    dur[0] = 16'h0000;
    for (int i = 1; i < 4; i++) dur[i] = 16'(3 + $urandom % 16);
    for (int i = 0; i < 4; i++) wreg(5'(jitter_pkg::A_DUR1 + i), dur[i]);
    stream(HWM | SRC | MOD | RUN, 90);
    for (int i = 0; i < 4; i++) `CHK("interval length", 32'(dur[i]) + 1, cnt[i + 1])
    `CHK("rest reached", 1'b1, cnt[5] > 0)
    rreg(jitter_pkg::A_CTRL, r);
    `CHK("run bit after rest", 1'b0, r[jitter_pkg::C_HW_RUN])
    // comparator start, then trigger pin start; the other input is ignored
    for (int k = 0; k < 2; k++) begin
      wreg(jitter_pkg::A_CTRL, HWM | MOD | (k ? EXT : 16'h0000));
      @(posedge mclk);
      if (k) ov_cmp <= 1'b1; else ext_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      ov_cmp <= 1'b0;
      ext_pin <= 1'b0;
      sect;
      `CHK("other source ignored", 1'b1, s == 3'h0 || s == 3'h5)
      @(posedge mclk);
      if (k) ext_pin <= 1'b1; else ov_cmp <= 1'b1;
      repeat (6) @(posedge mclk);
      ov_cmp <= 1'b0;
      ext_pin <= 1'b0;
      sect;
      `CHK("edge start", 1'b1, s != 3'h0 && s != 3'h5)
      repeat (100) @(posedge mclk);
    end
    // start refused while the auto-adjust flag is up
    @(posedge mclk);
    auto_adj <= 1'b1;
    wreg(jitter_pkg::A_CTRL, HWM | SRC | MOD | RUN);
    rreg(jitter_pkg::A_CTRL, r);
    `CHK("run refused", 1'b0, r[jitter_pkg::C_HW_RUN])
    sect;
    `CHK("no section", 1'b1, s == 3'h0 || s == 3'h5)
    @(posedge mclk);
    auto_adj <= 1'b0;
    // guard event mid-run
    wreg(jitter_pkg::A_CTRL, HWM | SRC | MOD | RUN | SWEN);
    @(posedge mclk);
    guard <= 1'b1;
    @(posedge mclk);
    guard <= 1'b0;
    rd <= 1'b1;
    addr <= jitter_pkg::A_CTRL;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    `CHK("run and enable cleared", 2'h0, rdata[1:0])
    `CHK("guard owns output", 1'b1, owns)
    sect;
    `CHK("guard stops timer", 3'h0, s)
    wreg(jitter_pkg::A_CTRL, SWEN);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("output handed back", 1'b0, owns)
    // full approach to one target, free and then against the ceiling
    for (int k = 0; k < 2; k++) begin
      p0 = 12'h020 + 12'($urandom % 16);
      st = 3'(1 + $urandom % 7);
      tg = p0 + 12'(1 + $urandom % (8 * st));
      pm = p0 + 12'($urandom % (tg - p0));
      wreg(jitter_pkg::A_CTRL, 16'h0000);
      wreg(jitter_pkg::A_STAT, 16'h000F);
      wreg(jitter_pkg::A_PER, 16'(p0));
      wreg(jitter_pkg::A_DUTY, 16'h0100);
      wreg(jitter_pkg::A_PMAX, 16'(pm));
      wreg(jitter_pkg::A_TPA, 16'(tg));
      wreg(jitter_pkg::A_TPB, 16'(tg));
      wreg(jitter_pkg::A_APPR, 16'(st) << jitter_pkg::P_PSTEP);
      for (int i = 0; i < 4; i++) wreg(5'(jitter_pkg::A_DUR1 + i), 16'h0180);
      stream(HWM | APS | SRC | MOD | RUN | (k ? LIM : 16'h0000), 1600);
      ed = 12'h100;
      ex = exp_final(p0, tg, st, k[0], pm, ed);
      `CHK("final period", ex[11:0], per)
      `CHK("final duty", ed, duty)
      rreg(jitter_pkg::A_STAT, r);
      `CHK("reached flag", !ex[12], |r[1:0])
      `CHK("limit flag", ex[12], |r[3:2])
      rreg(jitter_pkg::A_STAT, d);
      `CHK("flags re-read", {ex[12], !ex[12]}, {|d[3:2], |d[1:0]})
    end
    // a write while the clock enable is low must not land
    @(posedge mclk);
    ce <= 1'b0;
    wreg(jitter_pkg::A_PER, 16'h0123);
    @(posedge mclk);
    ce <= 1'b1;
    rreg(jitter_pkg::A_PER, r);
    `CHK("write frozen", {4'h0, ex[11:0]}, r)
    tally_and_finish;
  end
endmodule
`default_nettype wire
